// ---- src/lhb_core.sv ----
// register slice: pin readback, break and delimiter timing, header break sender
`timescale 1ns/10ps
`default_nettype none
`include "lhb_defs.svh"
module lhb_core
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        clk_en_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        bit_tick_i,
  input  wire logic        bus_in_pin_i,
  input  wire logic        bus_out_sense_i,
  output logic             bus_out_pin_o,
  output logic      [2:0]  break_extend_count_o,
  output logic      [1:0]  break_delimiter_length_o,
  output logic             sync_start_o
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] rx_sync_q, rx_sync_d;
  logic [1:0] tx_sync_q, tx_sync_d;
  // first stage feeds only the second one
  always_comb
  begin
    rx_sync_d = {rx_sync_q[0], bus_in_pin_i};
    tx_sync_d = {tx_sync_q[0], bus_out_sense_i};
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      rx_sync_q <= 2'h3;
      tx_sync_q <= 2'h3;
    end
    else if (clk_en_i)
    begin
      rx_sync_q <= rx_sync_d;
      tx_sync_q <= tx_sync_d;
    end
  end

  // ==========================================================
  // registers and avalon slave
  lhb_pkg::lhb_cfg_s cfg_q, cfg_d;
  logic              go_q, go_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              wait_q, wait_d;
  logic              busy;
  logic              access;
  assign access = avs_read_i | avs_write_i;
  // one wait cycle per access keeps read data registered
  always_comb
  begin
    cfg_d   = cfg_q;
    go_d    = 1'b0;
    rdata_d = rdata_q;
    wait_d  = 1'b1;
    if (access && wait_q)
    begin
      wait_d = 1'b0;
      rdata_d = 32'h0000_0000;
      case (avs_address_i)
        `LHB_OFS_PIN:
        begin
          rdata_d[`LHB_PIN_TX_BIT] = tx_sync_q[1];
          rdata_d[`LHB_PIN_RX_BIT] = rx_sync_q[1];
        end
        `LHB_OFS_BRK:
        begin
          rdata_d[`LHB_DEL_MSB:`LHB_DEL_LSB] = cfg_q.del;
          rdata_d[`LHB_EXT_MSB:`LHB_EXT_LSB] = cfg_q.ext;
          if (avs_write_i && avs_byteenable_i[1])
            cfg_d.del = avs_writedata_i[`LHB_DEL_MSB:`LHB_DEL_LSB];
          if (avs_write_i && avs_byteenable_i[0])
            cfg_d.ext = avs_writedata_i[`LHB_EXT_MSB:`LHB_EXT_LSB];
        end
        `LHB_OFS_CTRL:
        begin
          rdata_d[`LHB_CTRL_LIN_BIT]  = cfg_q.lin;
          rdata_d[`LHB_CTRL_BUSY_BIT] = busy;
          if (avs_write_i && avs_byteenable_i[0])
          begin
            cfg_d.lin = avs_writedata_i[`LHB_CTRL_LIN_BIT];
            go_d      = avs_writedata_i[`LHB_CTRL_GO_BIT];
          end
        end
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      cfg_q   <= '0;
      go_q    <= 1'b0;
      rdata_q <= 32'h0000_0000;
      wait_q  <= 1'b1;
    end
    else if (clk_en_i)
    begin
      cfg_q   <= cfg_d;
      go_q    <= go_d;
      rdata_q <= rdata_d;
      wait_q  <= wait_d;
    end
  end

  // ==========================================================
  // header break and delimiter sequencer
  lhb_pkg::lhb_state_e st_q, st_d;
  logic [4:0]          cnt_q, cnt_d;
  logic                out_q, out_d;
  logic                sync_q, sync_d;
  logic [4:0]          brk_len;
  logic [4:0]          del_len;
  assign brk_len = `LHB_BRK_MIN + {2'h0, cfg_q.ext};
  // outside LIN mode the delimiter is fixed at one bit time
  assign del_len = cfg_q.lin ? {3'h0, cfg_q.del} + 5'h01 : 5'h01;
  assign busy = (st_q != lhb_pkg::LHB_IDLE);
  always_comb
  begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    out_d  = out_q;
    sync_d = 1'b0;
    case (st_q)
      lhb_pkg::LHB_IDLE:
        if (go_q && cfg_q.lin)
        begin
          st_d  = lhb_pkg::LHB_BREAK;
          cnt_d = brk_len;
          out_d = 1'b0;
        end
      lhb_pkg::LHB_BREAK:
        if (bit_tick_i)
        begin
          cnt_d = cnt_q - 5'h01;
          if (cnt_q == 5'h01)
          begin
            st_d  = lhb_pkg::LHB_DELIM;
            cnt_d = del_len;
            out_d = 1'b1;
          end
        end
      lhb_pkg::LHB_DELIM:
        if (bit_tick_i)
        begin
          cnt_d = cnt_q - 5'h01;
          if (cnt_q == 5'h01)
            st_d = lhb_pkg::LHB_SYNC;
        end
      lhb_pkg::LHB_SYNC:
      begin
        sync_d = 1'b1;
        st_d   = lhb_pkg::LHB_IDLE;
      end
      default: st_d = lhb_pkg::LHB_IDLE;
    endcase
  end
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      st_q   <= lhb_pkg::LHB_IDLE;
      cnt_q  <= 5'h00;
      out_q  <= 1'b1;
      sync_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      out_q  <= out_d;
      sync_q <= sync_d;
    end
  end

  // ==========================================================
  // outputs, each straight from a flip-flop
  logic [2:0] ext_o_q;
  logic [1:0] del_o_q;
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ext_o_q <= 3'h0;
      del_o_q <= 2'h0;
    end
    else if (clk_en_i)
    begin
      ext_o_q <= cfg_q.ext;
      del_o_q <= cfg_q.lin ? cfg_q.del : 2'h0;
    end
  end
  assign avs_readdata_o           = rdata_q;
  assign avs_waitrequest_o        = wait_q;
  assign bus_out_pin_o            = out_q;
  assign sync_start_o             = sync_q;
  assign break_extend_count_o     = ext_o_q;
  assign break_delimiter_length_o = del_o_q;

  // ==========================================================
  // checks
  sequence s_break_end;
    (st_q == lhb_pkg::LHB_BREAK) ##1 (st_q == lhb_pkg::LHB_DELIM);
  endsequence
  chk_ext_reset: assert property (@(posedge mclk_i) $fell(sys_rst_i) |-> cfg_q.ext == 3'h0)
    else $error("extend field not zero after reset");
  chk_break_low: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (st_q == lhb_pkg::LHB_BREAK) |-> !out_q)
    else $error("pin high during break");
  chk_delim_high: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_break_end |-> out_q && cnt_q == del_len)
    else $error("delimiter not loaded");
  chk_break_len: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (st_q == lhb_pkg::LHB_IDLE && go_q && cfg_q.lin && clk_en_i)
    |=> cnt_q == `LHB_BRK_MIN + {2'h0, $past(cfg_q.ext)})
    else $error("break length wrong");
  chk_delim_mode: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !cfg_q.lin |-> del_len == 5'h01)
    else $error("delimiter used outside lin mode");
  chk_sync_after: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    sync_q |-> $past(st_q) == lhb_pkg::LHB_SYNC && out_q)
    else $error("sync started early");
  chk_rx_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (wait_q && avs_read_i && clk_en_i && avs_address_i == `LHB_OFS_PIN)
    |=> avs_readdata_o[2:1] == $past({tx_sync_q[1], rx_sync_q[1]}))
    else $error("pin readback wrong");
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !avs_waitrequest_o |-> avs_readdata_o[31:10] == 22'h0 && avs_readdata_o[7:3] == 5'h0)
    else $error("reserved bits not zero");
endmodule
`default_nettype wire

// ---- src/lhb_defs.svh ----
// constants for the header break timing and pin readback slice
`ifndef LHB_DEFS_SVH
`define LHB_DEFS_SVH
`define LHB_OFS_PIN       4'h0
`define LHB_OFS_BRK       4'h4
`define LHB_OFS_CTRL      4'h8
`define LHB_PIN_TX_BIT    2
`define LHB_PIN_RX_BIT    1
`define LHB_DEL_LSB       8
`define LHB_DEL_MSB       9
`define LHB_EXT_LSB       0
`define LHB_EXT_MSB       2
`define LHB_BRK_MIN       5'h0d
`define LHB_CTRL_LIN_BIT  0
`define LHB_CTRL_GO_BIT   1
`define LHB_CTRL_BUSY_BIT 2
`endif

// ---- src/lhb_pkg.sv ----
// types for the header break timing and pin readback slice
`default_nettype none
package lhb_pkg;
  typedef enum logic [1:0] {
    LHB_IDLE  = 2'b00,
    LHB_BREAK = 2'b01,
    LHB_DELIM = 2'b10,
    LHB_SYNC  = 2'b11
  } lhb_state_e;
  typedef struct packed {
    logic [1:0] del;
    logic [2:0] ext;
    logic       lin;
  } lhb_cfg_s;
endpackage
`default_nettype wire

// ---- tb/lhb_xcvr_model.sv ----
// bus transceiver model facing the header sender
`timescale 1ns/10ps
`default_nettype none
module lhb_xcvr_model
(
  input  wire logic mclk_i,
  input  wire logic tx_i,
  input  wire logic dom_i,
  output logic      rx_o,
  output logic      sense_o
);
  // ==========================================
  // wired-and bus: a dominant node pulls it low, one cycle of line delay
  always_ff @(posedge mclk_i)
  begin
    rx_o    <= tx_i & ~dom_i;
    sense_o <= tx_i;
  end
endmodule
`default_nettype wire

// ---- tb/lhb_core_test.sv ----
// self-checking bench for the header timing and pin readback slice
`timescale 1ns/10ps
`default_nettype none
module lhb_core_test;
  logic        mclk_i = 0, sys_rst_i = 1, rd_i = 0, wr_i = 0, tick = 0, dom = 0;
  logic [3:0]  adr = 0, tc = 0;
  logic [31:0] wd = 0, rdata, d;
  logic        wait_o, pin_o, rx, sense, sync_o;
  logic [2:0]  ext_o;
  logic [1:0]  del_o;
  logic [31:0] q[$];
  integer      n_fail = 0, n_tests = 0, seed = 32'he3ab;
  int          lo = 0, hi = 0;
  logic        win = 0;
  lhb_core dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1),
    .avs_address_i(adr), .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o),
    .bit_tick_i(tick), .bus_in_pin_i(rx), .bus_out_sense_i(sense), .bus_out_pin_o(pin_o),
    .break_extend_count_o(ext_o), .break_delimiter_length_o(del_o), .sync_start_o(sync_o));
  lhb_xcvr_model xcvr (.mclk_i(mclk_i), .tx_i(pin_o), .dom_i(dom), .rx_o(rx), .sense_o(sense));
  // ==========================================
  // clock, and a bit tick every 16 cycles so reads fit inside a break
  always #2 mclk_i = ~mclk_i;
  always @(posedge mclk_i)
  begin
    tc   <= tc + 4'h1;
    tick <= (tc == 4'hf);
  end
  // header ticks counted mid-cycle, where tick and pin have settled, so none is missed
  always @(negedge mclk_i)
  begin
    if (!win)
    begin
      lo = 0;
      hi = 0;
    end
    else if (tick && pin_o === 1'b0)
      lo++;
    else if (tick && lo > 0)
      hi++;
  end
  // read answers are compared against the oldest queued note
  always @(posedge mclk_i)
    if (rd_i && wait_o === 1'b0)
      chk("readdata", rdata, q.pop_front());
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // request held until waitrequest is seen low, then one idle cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    adr <= a;
    wd <= v;
    wr_i <= w;
    rd_i <= ~w;
    do @(posedge mclk_i); while (wait_o !== 1'b0 && ++n < 50);
    if (n >= 50)
    begin
      n_fail++;
      finish_test();
    end
    rd_i <= 1'b0;
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdx(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  // send one header and count ticks of the low break and the high delimiter
  task automatic hdr(input logic [2:0] e, input logic [1:0] dl);
    int n;
    n = 0;
    win <= 1'b1;
    bus(1'b1, 4'h4, {22'h0, dl, 5'h0, e});
    bus(1'b1, 4'h8, 32'h0000_0003);
    chk("delim_out", {30'h0, del_o}, {30'h0, dl});
    chk("extend_out", {29'h0, ext_o}, {29'h0, e});
    fork
      begin repeat (40) @(posedge mclk_i); rdx(4'h0, 32'h0000_0000); end
    join_none
    while (sync_o !== 1'b1 && ++n < 800) @(negedge mclk_i);
    if (n >= 800)
    begin
      n_fail++;
      finish_test();
    end
    @(posedge mclk_i);
    chk("break_ticks", lo, 13 + e);
    chk("delim_ticks", hi, dl + 1);
    win <= 1'b0;
    repeat (20) @(posedge mclk_i);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rdx(4'h0, 32'h0000_0006);
    rdx(4'h4, 32'h0000_0000);
    dom <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rdx(4'h0, 32'h0000_0004);
    dom <= 1'b0;
    repeat (6) @(posedge mclk_i);
    d = $random(seed);
    bus(1'b1, 4'h4, d);
    rdx(4'h4, d & 32'h0000_0307);
    bus(1'b1, 4'h0, 32'hffff_ffff);
    rdx(4'h0, 32'h0000_0006);
    rdx(4'hc, 32'h0000_0000);
    for (int i = 0; i < 4; i++) hdr(i[0] ? 3'h7 : 3'h0, i[1:0]);
    rdx(4'h8, 32'h0000_0001);
    bus(1'b1, 4'h8, 32'h0000_0000);
    chk("delim_sci", {30'h0, del_o}, 32'h0000_0000);
    bus(1'b1, 4'h8, 32'h0000_0002);
    rdx(4'h8, 32'h0000_0000);
    rdx(4'h0, 32'h0000_0006);
    dom <= 1'b1;
    repeat (6) @(posedge mclk_i);
    rdx(4'h0, 32'h0000_0004);
    dom <= 1'b0;
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    rdx(4'h4, 32'h0000_0000);
    rdx(4'h0, 32'h0000_0006);
    finish_test();
  end
endmodule
`default_nettype wire
